// *** ofm_core.sv ***
`timescale 1ns/1ps
`include "ofm_defs.svh"

// Functional notes
// - OR accumulator with addressed file register
// - OR result to accumulator or back to file
// - Move file register to selected destination
// - Destination bit zero accumulator, one file
// - File register move updates zero flag from moved value
module ofm_core (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [11:0] instr_i,
	input wire logic instr_valid_i,
	input wire logic host_wr_i,
	input wire logic [4:0] host_addr_i,
	input wire logic [7:0] host_data_i,
	output logic [7:0] acc_o,
	output logic zero_o,
	output logic done_o,
	output ofm_pkg::ofm_file_wr_t file_wr_o
);

	ofm_pkg::ofm_state_t state;
	ofm_pkg::ofm_state_t next_state;
	logic [7:0] rd_data;
	logic mem_wr_en;
	logic [4:0] mem_wr_addr;
	logic [7:0] mem_wr_data;

	// ==========================================
	// File register memory
	// Writeback wins the single write port; a host load in that clock is dropped
	always_comb begin
		if (state.phase == ofm_pkg::PH_WRITE && state.dest &&
			(state.op == ofm_pkg::OP_IOR || state.op == ofm_pkg::OP_MOVE_FILE ||
			state.op == ofm_pkg::OP_MOVE_ACC)) begin
			mem_wr_en = 1'b1;
			mem_wr_addr = state.addr;
			mem_wr_data = state.res;
		end else begin
			mem_wr_en = host_wr_i;
			mem_wr_addr = host_addr_i;
			mem_wr_data = host_data_i;
		end
	end

	ofm_file_mem #(
		.DW(`OFM_DATA_W),
		.AW(`OFM_ADDR_W),
		.DEPTH(`OFM_FILE_DEPTH)
	) u_mem (
		.clk_i(clk_i),
		.wr_en_i(mem_wr_en),
		.wr_addr_i(mem_wr_addr),
		.wr_data_i(mem_wr_data),
		.rd_addr_i(state.addr),
		.rd_data_o(rd_data)
	);

	// ==========================================
	// Decode, execute, writeback over four phases
	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		next_state.file_wr.en = 1'b0;
		unique case (state.phase)
			ofm_pkg::PH_FETCH: begin
				next_state.phase = ofm_pkg::PH_READ;
				next_state.op = ofm_pkg::OP_NONE;
				next_state.dest = instr_i[`OFM_DEST_BIT];
				next_state.addr = instr_i[4:0];
				next_state.lit = instr_i[7:0];
				// Fields latch on every fetch; only the opcode is gated, so an invalid word is a no-op
				if (instr_valid_i) begin
					if (instr_i[11:6] == `OFM_OP_IOR_HI) begin
						next_state.op = ofm_pkg::OP_IOR;
					end else if (instr_i[11:6] == `OFM_OP_MOVE_FILE_HI) begin
						next_state.op = ofm_pkg::OP_MOVE_FILE;
					end else if (instr_i[11:8] == `OFM_OP_MOVE_LIT_HI) begin
						next_state.op = ofm_pkg::OP_MOVE_LIT;
					end else if (instr_i[11:5] == `OFM_OP_MOVE_ACC_HI) begin
						next_state.op = ofm_pkg::OP_MOVE_ACC;
						next_state.dest = 1'b1;
					end
				end
			end
			ofm_pkg::PH_READ: begin
				next_state.phase = ofm_pkg::PH_EXEC;
			end
			ofm_pkg::PH_EXEC: begin
				next_state.phase = ofm_pkg::PH_WRITE;
				unique case (state.op)
					ofm_pkg::OP_IOR: next_state.res = state.acc | rd_data;
					ofm_pkg::OP_MOVE_FILE: next_state.res = rd_data;
					ofm_pkg::OP_MOVE_LIT: next_state.res = state.lit;
					ofm_pkg::OP_MOVE_ACC: next_state.res = state.acc;
					ofm_pkg::OP_NONE: next_state.res = state.res;
					default: next_state.res = state.res;
				endcase
			end
			ofm_pkg::PH_WRITE: begin
				next_state.phase = ofm_pkg::PH_FETCH;
				next_state.done = 1'b1;
				if (state.op == ofm_pkg::OP_IOR || state.op == ofm_pkg::OP_MOVE_FILE) begin
					next_state.zero = (state.res == 8'h00);
					if (state.dest) begin
						next_state.file_wr.en = 1'b1;
						next_state.file_wr.addr = state.addr;
						next_state.file_wr.data = state.res;
					end else begin
						next_state.acc = state.res;
					end
				// Literal and accumulator moves leave the zero flag alone
				end else if (state.op == ofm_pkg::OP_MOVE_LIT) begin
					next_state.acc = state.res;
				end else if (state.op == ofm_pkg::OP_MOVE_ACC) begin
					next_state.file_wr.en = 1'b1;
					next_state.file_wr.addr = state.addr;
					next_state.file_wr.data = state.res;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		// File memory keeps its contents through reset; only the core registers clear
		if (!rst_n_i) begin
			state <= '0;
			state.phase <= ofm_pkg::PH_FETCH;
			state.op <= ofm_pkg::OP_NONE;
			state.acc <= `OFM_ACC_RST;
			state.zero <= `OFM_ZERO_RST;
		end else begin
			state <= next_state;
		end
	end

	assign acc_o = state.acc;
	assign zero_o = state.zero;
	assign done_o = state.done;
	assign file_wr_o = state.file_wr;

	// ==========================================
	// Checks
	// Fetch at edge T, read T+1, execute T+2, write T+3; outputs are seen at T+4
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence at_write_s(ofm_pkg::ofm_op_t o);
		state.phase == ofm_pkg::PH_WRITE && state.op == o;
	endsequence

	sequence taken_s;
		state.phase == ofm_pkg::PH_FETCH && instr_valid_i &&
			(instr_i[11:6] == `OFM_OP_IOR_HI || instr_i[11:6] == `OFM_OP_MOVE_FILE_HI);
	endsequence

	sequence wb_s;
		state.phase == ofm_pkg::PH_WRITE && state.dest && (state.op == ofm_pkg::OP_IOR ||
			state.op == ofm_pkg::OP_MOVE_FILE || state.op == ofm_pkg::OP_MOVE_ACC);
	endsequence

	ior_value_a: assert property (
		at_write_s(ofm_pkg::OP_IOR) |-> state.res == (state.acc | $past(rd_data)))
		else $error("or result does not match accumulator or file");

	ior_dest_a: assert property (
		at_write_s(ofm_pkg::OP_IOR) |=>
			($past(state.dest) ? (file_wr_o.en && file_wr_o.data == $past(state.res) && $stable(acc_o))
			: (!file_wr_o.en && acc_o == $past(state.res))))
		else $error("or result went to wrong destination");

	move_copy_a: assert property (
		at_write_s(ofm_pkg::OP_MOVE_FILE) |-> state.res == $past(rd_data))
		else $error("moved value differs from file register");

	move_dest_a: assert property (
		at_write_s(ofm_pkg::OP_MOVE_FILE) ##1 !$past(state.dest) |-> acc_o == $past(state.res) && !file_wr_o.en)
		else $error("move with dest zero did not load accumulator");

	move_wb_a: assert property (
		at_write_s(ofm_pkg::OP_MOVE_FILE) ##1 $past(state.dest) |-> file_wr_o.en &&
			file_wr_o.addr == $past(state.addr) && file_wr_o.data == $past(state.res) && $stable(acc_o))
		else $error("move with dest one did not rewrite the file register");

	move_zero_a: assert property (
		at_write_s(ofm_pkg::OP_MOVE_FILE) |=> zero_o == ($past(state.res) == 8'h00))
		else $error("zero flag wrong after move");

	// A self move must put back exactly what was read, so it stays a pure zero test
	move_keep_a: assert property (
		at_write_s(ofm_pkg::OP_MOVE_FILE) ##0 state.dest |-> mem_wr_addr == state.addr && mem_wr_data == $past(rd_data))
		else $error("self move changed the file register contents");

	ior_zero_a: assert property (
		at_write_s(ofm_pkg::OP_IOR) |=> zero_o == ($past(state.res) == 8'h00))
		else $error("zero flag wrong after or");

	// Writeback must own the memory port in its write clock, whatever the host drives
	wb_port_a: assert property (
		wb_s |-> mem_wr_en && mem_wr_addr == state.addr && mem_wr_data == state.res)
		else $error("writeback missing from the memory port");

	one_cycle_a: assert property (
		taken_s |-> ##(`OFM_DONE_DELAY) done_o ##1 !done_o)
		else $error("instruction did not finish in one instruction cycle");

	done_period_a: assert property (
		done_o |=> !done_o [*3] ##1 done_o)
		else $error("instruction cycles are not four clocks apart");

	done_fetch_a: assert property (
		done_o |-> state.phase == ofm_pkg::PH_FETCH)
		else $error("completion pulse outside the fetch phase");

	lit_move_a: assert property (
		at_write_s(ofm_pkg::OP_MOVE_LIT) |=> acc_o == $past(state.lit) && $stable(zero_o) && !file_wr_o.en)
		else $error("literal move wrong");

	acc_move_a: assert property (
		at_write_s(ofm_pkg::OP_MOVE_ACC) |=> file_wr_o.en && file_wr_o.addr == $past(state.addr) &&
			file_wr_o.data == $past(state.acc) && $stable(zero_o))
		else $error("accumulator to file move wrong");

endmodule

// *** ofm_defs.svh ***
`ifndef OFM_DEFS_SVH
`define OFM_DEFS_SVH

// ==========================================
// Widths
`define OFM_INSTR_W 12
`define OFM_DATA_W 8
`define OFM_ADDR_W 5
`define OFM_FILE_DEPTH 32

// ==========================================
// Opcode patterns (upper bits of the instruction word)
`define OFM_OP_IOR_HI 6'h04
`define OFM_OP_MOVE_FILE_HI 6'h08
`define OFM_OP_MOVE_LIT_HI 4'hc
`define OFM_OP_MOVE_ACC_HI 7'h01
`define OFM_OP_NOP 12'h000
`define OFM_DEST_BIT 5

// ==========================================
// Timing: one instruction cycle is four clocks
`define OFM_PHASES 4
`define OFM_DONE_DELAY 4

// ==========================================
// Reset values
`define OFM_ACC_RST 8'h00
`define OFM_ZERO_RST 1'b0

`endif

// *** ofm_file_mem.sv ***
`timescale 1ns/1ps
`include "ofm_defs.svh"

module ofm_file_mem #(
	parameter int DW = `OFM_DATA_W,
	parameter int AW = `OFM_ADDR_W,
	parameter int DEPTH = `OFM_FILE_DEPTH
) (
	input wire logic clk_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [DW-1:0] wr_data_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [DW-1:0] rd_data_o
);

	logic [DW-1:0] mem [DEPTH];

	// ==========================================
	// Read data is registered, so it trails the address by one clock
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end

endmodule

// *** ofm_pkg.sv ***
package ofm_pkg;

	typedef enum logic [1:0] {
		PH_FETCH = 2'b00,
		PH_READ = 2'b01,
		PH_EXEC = 2'b10,
		PH_WRITE = 2'b11
	} ofm_phase_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_IOR = 3'b001,
		OP_MOVE_FILE = 3'b010,
		OP_MOVE_LIT = 3'b011,
		OP_MOVE_ACC = 3'b100
	} ofm_op_t;

	typedef struct packed {
		logic en;
		logic [4:0] addr;
		logic [7:0] data;
	} ofm_file_wr_t;

	typedef struct packed {
		ofm_phase_t phase;
		ofm_op_t op;
		logic dest;
		logic [4:0] addr;
		logic [7:0] lit;
		logic [7:0] res;
		logic [7:0] acc;
		logic zero;
		logic done;
		ofm_file_wr_t file_wr;
	} ofm_state_t;

endpackage

// *** or_and_move_file_ops_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module or_and_move_file_ops_tb;
	logic clk_i;
	logic rst_n_i;
	logic [11:0] instr_i;
	logic instr_valid_i;
	logic host_wr_i;
	logic [4:0] host_addr_i;
	logic [7:0] host_data_i;
	logic [7:0] acc_o;
	logic zero_o;
	logic done_o;
	ofm_pkg::ofm_file_wr_t file_wr_o;
	int bad_count = 0;
	int num_checks = 0;
	logic [4:0] pre_a [4] = '{5'h03, 5'h07, 5'h09, 5'h1f};
	logic [7:0] pre_d [4] = '{8'h00, 8'h35, 8'h5a, 8'h77};
	localparam ofm_pkg::ofm_file_wr_t NO_WR = '0;

	ofm_core DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
		.host_wr_i(host_wr_i), .host_addr_i(host_addr_i), .host_data_i(host_data_i), .acc_o(acc_o),
		.zero_o(zero_o), .done_o(done_o), .file_wr_o(file_wr_o));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// ==========================================
	// Helpers
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Entered at the falling edge just before a fetch edge; leaves an idle cycle so the next call lines up again
	task automatic exec(input logic [11:0] ins, input logic [7:0] ea, input logic ez, input ofm_pkg::ofm_file_wr_t ew);
		instr_i = ins;
		instr_valid_i = 1'b1;
		@(negedge clk_i);
		instr_valid_i = 1'b0;
		// A literal move left on the port catches sampling outside the fetch phase
		instr_i = 12'hc55;
		repeat (2) @(negedge clk_i);
		`CHK(done_o, 1'b0)
		@(negedge clk_i);
		`CHK(done_o, 1'b1)
		`CHK(acc_o, ea)
		`CHK(zero_o, ez)
		`CHK(file_wr_o.en, ew.en)
		if (ew.en) `CHK(file_wr_o, ew)
		repeat (4) @(negedge clk_i);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_or();
		exec(12'hc9a, 8'h9a, 1'b0, NO_WR);
		exec(12'h107, 8'hbf, 1'b0, NO_WR);
		exec(12'h129, 8'hbf, 1'b0, '{1'b1, 5'h09, 8'hff});
		$display("t_or finished");
	endtask

	task automatic t_move();
		exec(12'h203, 8'h00, 1'b1, NO_WR);
		exec(12'h229, 8'h00, 1'b0, '{1'b1, 5'h09, 8'hff});
		exec(12'h21f, 8'h77, 1'b0, NO_WR);
		$display("t_move finished");
	endtask

	task automatic t_zero();
		exec(12'hc00, 8'h00, 1'b0, NO_WR);
		exec(12'h103, 8'h00, 1'b1, NO_WR);
		exec(12'h03f, 8'h00, 1'b1, '{1'b1, 5'h1f, 8'h00});
		exec(12'h000, 8'h00, 1'b1, NO_WR);
		exec(12'h23f, 8'h00, 1'b1, '{1'b1, 5'h1f, 8'h00});
		exec(12'h209, 8'hff, 1'b0, NO_WR);
		$display("t_zero finished");
	endtask

	task automatic t_reset();
		rst_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		`CHK(acc_o, 8'h00)
		`CHK(zero_o, 1'b0)
		`CHK(done_o, 1'b0)
		`CHK(file_wr_o, NO_WR)
		rst_n_i = 1'b1;
		// First instruction lands on the first edge after release; file memory keeps its contents
		exec(12'h209, 8'hff, 1'b0, NO_WR);
		$display("t_reset finished");
	endtask

	initial begin
		#2000000;
		bad_count++;
		end_sim();
	end

	initial begin
		rst_n_i = 1'b0;
		instr_i = 12'h000;
		instr_valid_i = 1'b0;
		host_wr_i = 1'b0;
		host_addr_i = 5'h00;
		host_data_i = 8'h00;
		repeat (10) @(posedge clk_i);
		@(negedge clk_i);
		rst_n_i = 1'b1;
		`CHK(acc_o, 8'h00)
		`CHK(zero_o, 1'b0)
		`CHK(done_o, 1'b0)
		// Preload fills the first instruction cycle, which runs with no valid instruction
		for (int i = 0; i < 4; i++) begin
			host_wr_i = 1'b1;
			host_addr_i = pre_a[i];
			host_data_i = pre_d[i];
			@(posedge clk_i);
			@(negedge clk_i);
		end
		host_wr_i = 1'b0;
		t_or();
		t_move();
		t_zero();
		t_reset();
		end_sim();
	end
endmodule
